// ==== rtl/pfb_pkg.sv ====
package pfb_pkg;
  // register byte addresses
  localparam logic [7:0] CTRL_OFF   = 8'h00; // pll_control_reg
  localparam logic [7:0] BW_OFF     = 8'h04; // pll_bandwidth_reg
  localparam logic [7:0] BRK_OFF    = 8'h08; // break_flag_control_reg
  localparam logic [7:0] IST_OFF    = 8'h0c; // irq status, read only
  localparam logic [7:0] ICLR_OFF   = 8'h10; // irq clear, write only
  localparam logic [7:0] IEN_OFF    = 8'h14; // irq enable
  // control register fields
  localparam int CTRL_IE_BIT   = 7; // pll_irq_enable
  localparam int CTRL_FLAG_BIT = 6; // pll_lock_change_flag, write 0 to clear
  // bandwidth register fields
  localparam int BW_AUTO_BIT   = 7;
  localparam int BW_LOCK_BIT   = 6;
  localparam int BW_TRK_BIT    = 5; // tracking_mode_indicator
  // break control fields
  localparam int BRK_CLR_EN_BIT = 7; // break_clear_flag_enable
  // irq status fields
  localparam int IST_LOCK_BIT  = 0; // lock indicator changed
  localparam int IST_TRK_BIT   = 1; // tracking entered
  localparam int NUM_IRQ       = 2;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // reset values
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
endpackage : pfb_pkg

// ==== rtl/pfb_sync.sv ====
`timescale 1ns/10ps
// two-stage synchroniser for the analog loop indications
module pfb_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage is read only by second stage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : pfb_sync

// ==== rtl/pfb_top.sv ====
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// What this block does
// - clear enable lets software clear flags in break
// - flag cleared in break stays cleared
// - clear enable low protects lock-change flag in break while auto mode stays on
// - clear enable resets to zero
// - auto mode sets tracking indicator below tolerance
// - auto mode sets lock indicator below tolerance
// - lock change sets flag; manual reads zero
// - manual mode lock indicator reads zero
module pfb_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // axi4-lite write address
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  // axi4-lite write response
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  // axi4-lite read data
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // loop comparator levels from the analog pll
  input  wire logic        trk_err_ok,
  input  wire logic        lock_err_ok,
  // break logic of the system integration unit
  input  wire logic        break_active,
  // interrupt and loop mode
  output logic             pll_irq,
  output logic             bw_auto
);
  typedef struct packed {
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       have_aw;
    logic       have_w;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic       irq_en;
    logic       flag;
    logic       auto_mode;
    logic       manual_trk;
    logic       lock;
    logic       trk;
    logic       clr_en;
    logic [pfb_pkg::NUM_IRQ-1:0] ist;
    logic [pfb_pkg::NUM_IRQ-1:0] ien;
    logic       irq;
  } pfb_state_s;

  pfb_state_s st_reg;
  pfb_state_s st_next;
  logic [1:0] loop_sync;

  // bring loop levels onto mclk
  pfb_sync #(.W(2)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({lock_err_ok, trk_err_ok}),
    .q    (loop_sync)
  );

  // read mux shared by the read channel
  function automatic logic [31:0] rd_word(input pfb_state_s s, input logic [7:0] a,
                                          output logic ok);
    logic [31:0] v;
    v  = pfb_pkg::WORD_ZERO;
    ok = 1'b1;
    if (a == pfb_pkg::CTRL_OFF) begin
      v[pfb_pkg::CTRL_IE_BIT]   = s.irq_en;
      v[pfb_pkg::CTRL_FLAG_BIT] = s.flag & s.auto_mode;
    end else if (a == pfb_pkg::BW_OFF) begin
      v[pfb_pkg::BW_AUTO_BIT] = s.auto_mode;
      v[pfb_pkg::BW_LOCK_BIT] = s.lock & s.auto_mode;
      v[pfb_pkg::BW_TRK_BIT]  = s.auto_mode ? s.trk : s.manual_trk;
    end else if (a == pfb_pkg::BRK_OFF) begin
      v[pfb_pkg::BRK_CLR_EN_BIT] = s.clr_en;
    end else if (a == pfb_pkg::IST_OFF) begin
      v[pfb_pkg::NUM_IRQ-1:0] = s.ist;
    end else if (a == pfb_pkg::IEN_OFF) begin
      v[pfb_pkg::NUM_IRQ-1:0] = s.ien;
    end else if (a == pfb_pkg::ICLR_OFF) begin
      v = pfb_pkg::WORD_ZERO;
    end else begin
      ok = 1'b0;
    end
    return v;
  endfunction : rd_word

  // next state
  always_comb begin
    logic        wr_go;
    logic        rd_ok;
    logic        clr_ok;
    logic        lock_new;
    logic        trk_new;
    logic [pfb_pkg::NUM_IRQ-1:0] ev;
    logic [pfb_pkg::NUM_IRQ-1:0] clr;
    logic [31:0] rv;
    wr_go    = 1'b0;
    rd_ok    = 1'b0;
    clr_ok   = 1'b0;
    lock_new = 1'b0;
    trk_new  = 1'b0;
    ev       = '0;
    clr      = '0;
    rv       = pfb_pkg::WORD_ZERO;
    st_next  = st_reg;

    // write address and data taken in either order
    if (s_awvalid && st_reg.awready) begin
      st_next.have_aw = 1'b1;
      st_next.awaddr  = s_awaddr;
      st_next.awready = 1'b0;
    end
    if (s_wvalid && st_reg.wready) begin
      st_next.have_w = 1'b1;
      st_next.wdata  = s_wdata;
      st_next.wstrb  = s_wstrb;
      st_next.wready = 1'b0;
    end
    wr_go = st_reg.have_aw && st_reg.have_w && !st_reg.bvalid;

    // flag clears by write only outside break or with clear enable set; manual mode clears it always
    clr_ok = !break_active || st_reg.clr_en;

    // loop indications only move in auto mode
    lock_new = st_reg.auto_mode & loop_sync[1];
    trk_new  = st_reg.auto_mode & loop_sync[0];
    st_next.lock = lock_new;
    st_next.trk  = trk_new;
    ev[pfb_pkg::IST_LOCK_BIT] = st_reg.auto_mode && (lock_new != st_reg.lock);
    ev[pfb_pkg::IST_TRK_BIT]  = trk_new && !st_reg.trk;

    if (wr_go) begin
      st_next.have_aw = 1'b0;
      st_next.have_w  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = pfb_pkg::RESP_OKAY;
      if (st_reg.awaddr == pfb_pkg::CTRL_OFF) begin
        if (st_reg.wstrb[0]) begin
          st_next.irq_en = st_reg.wdata[pfb_pkg::CTRL_IE_BIT];
          if (!st_reg.wdata[pfb_pkg::CTRL_FLAG_BIT] && clr_ok) begin
            st_next.flag = 1'b0;
          end
        end
      end else if (st_reg.awaddr == pfb_pkg::BW_OFF) begin
        if (st_reg.wstrb[0]) begin
          st_next.auto_mode = st_reg.wdata[pfb_pkg::BW_AUTO_BIT];
          if (!st_reg.auto_mode) begin
            st_next.manual_trk = st_reg.wdata[pfb_pkg::BW_TRK_BIT];
          end
        end
      end else if (st_reg.awaddr == pfb_pkg::BRK_OFF) begin
        if (st_reg.wstrb[0]) begin
          st_next.clr_en = st_reg.wdata[pfb_pkg::BRK_CLR_EN_BIT];
        end
      end else if (st_reg.awaddr == pfb_pkg::ICLR_OFF) begin
        if (st_reg.wstrb[0] && clr_ok) begin
          clr = st_reg.wdata[pfb_pkg::NUM_IRQ-1:0];
        end
      end else if (st_reg.awaddr == pfb_pkg::IEN_OFF) begin
        if (st_reg.wstrb[0]) begin
          st_next.ien = st_reg.wdata[pfb_pkg::NUM_IRQ-1:0];
        end
      end else if (st_reg.awaddr != pfb_pkg::IST_OFF) begin
        st_next.bresp = pfb_pkg::RESP_SLVERR;
      end
    end

    // lock change sets flag; set beats clear
    if (ev[pfb_pkg::IST_LOCK_BIT]) begin
      st_next.flag = 1'b1;
    end
    if (!st_reg.auto_mode) begin
      st_next.flag = 1'b0;
    end
    st_next.ist = (st_reg.ist & ~clr) | ev;

    // write response handshake
    if (st_reg.bvalid && s_bready) begin
      st_next.bvalid  = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end

    // read channel, one access at a time
    if (s_arvalid && st_reg.arready) begin
      rv = rd_word(st_reg, s_araddr, rd_ok);
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      st_next.rdata   = rv;
      st_next.rresp   = rd_ok ? pfb_pkg::RESP_OKAY : pfb_pkg::RESP_SLVERR;
    end else if (st_reg.rvalid && s_rready) begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end

    st_next.irq = |(st_next.ist & st_next.ien);
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg         <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready  <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.clr_en  <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign s_awready = st_reg.awready;
  assign s_wready  = st_reg.wready;
  assign s_bvalid  = st_reg.bvalid;
  assign s_bresp   = st_reg.bresp;
  assign s_arready = st_reg.arready;
  assign s_rvalid  = st_reg.rvalid;
  assign s_rdata   = st_reg.rdata;
  assign s_rresp   = st_reg.rresp;
  assign pll_irq   = st_reg.irq;
  assign bw_auto   = st_reg.auto_mode;
endmodule : pfb_top

// ==== dv/pfb_properties.sv ====
`timescale 1ns/10ps
// bus timing and readback checks seen at the top ports
module pfb_properties (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // loop mode
  input wire logic        bw_auto,
  // write channels
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  // read channels
  input wire logic [7:0]  s_araddr,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0]  s_rresp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rd_lat; s_arvalid && s_arready |=> s_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat; s_awvalid && s_awready && s_wvalid && s_wready |-> ##[2:3] s_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_r_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_hold; s_bvalid && !s_bready |=> s_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_unmap; s_arvalid && s_arready && s_araddr > pfb_pkg::IEN_OFF |=>
    s_rresp == pfb_pkg::RESP_SLVERR && s_rdata == pfb_pkg::WORD_ZERO; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_upper; s_rvalid |-> s_rdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_lock_man; s_arvalid && s_arready && s_araddr == pfb_pkg::BW_OFF && !bw_auto
    |=> !s_rdata[pfb_pkg::BW_LOCK_BIT]; endproperty
  a_lock_man: assert property (p_lock_man) else $error("lock set in manual");
  property p_flag_man; s_arvalid && s_arready && s_araddr == pfb_pkg::CTRL_OFF && !bw_auto
    |=> !s_rdata[pfb_pkg::CTRL_FLAG_BIT]; endproperty
  a_flag_man: assert property (p_flag_man) else $error("flag set in manual");
endmodule : pfb_properties
bind pfb_top pfb_properties i_props (.mclk, .rst, .bw_auto, .s_awvalid, .s_awready, .s_wvalid,
  .s_wready, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rvalid, .s_rready,
  .s_rdata, .s_rresp);

// ==== dv/pfb_far_model.sv ====
`timescale 1ns/10ps
// analog loop comparators and break source; settle sets how slowly lock comes
module pfb_far_model #(
  parameter int SETTLE = 4
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // test controls
  input  wire logic pll_on,
  input  wire logic brk_req,
  // comparator levels and break state
  output logic      trk_err_ok,
  output logic      lock_err_ok,
  output logic      break_active
);
  int cnt;
  // error shrinks under tracking tolerance first, then under lock tolerance
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      trk_err_ok <= 1'b0;
      lock_err_ok <= 1'b0;
      break_active <= 1'b0;
    end else begin
      cnt <= pll_on ? ((cnt < 2 * SETTLE) ? cnt + 1 : cnt) : 0;
      trk_err_ok <= pll_on && cnt >= SETTLE;
      lock_err_ok <= pll_on && cnt >= 2 * SETTLE;
      break_active <= brk_req;
    end
  end
endmodule : pfb_far_model

// ==== dv/pll_flag_break_protect_tb.sv ====
`timescale 1ns/10ps
module pll_flag_break_protect_tb;
  logic        mclk, rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, pll_on, brk_req;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, pll_irq, bw_auto;
  logic        trk_err_ok, lock_err_ok, break_active;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, msk;
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  pfb_top i_dut (.mclk, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .trk_err_ok, .lock_err_ok, .break_active, .pll_irq, .bw_auto);
  pfb_far_model #(.SETTLE(4)) i_far (.mclk, .rst, .pll_on, .brk_req, .trk_err_ok, .lock_err_ok,
    .break_active);
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  function automatic logic exp_irq(input logic [1:0] st, en);
    return |(st & en);
  endfunction : exp_irq
  task automatic chk(input logic [31:0] got, exp, input string nm);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // write cycle: address and data offered together, each released at the edge that takes it
  // handshakes are judged on values read just after the edge, before the design updates
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge mclk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    chk({30'h0, s_bresp}, {30'h0, r}, "bresp");
    s_bready <= 1'b0;
  endtask : wr
  // read cycle with data and response compare at the handshake edge
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r,
                     input string nm);
    @(posedge mclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    chk(s_rdata, e, nm);
    chk({30'h0, s_rresp}, {30'h0, r}, nm);
    s_rready <= 1'b0;
  endtask : rdc
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, pll_on, brk_req} = '0;
    s_awaddr = 8'h00; s_araddr = 8'h00; s_wdata = 32'h0; s_wstrb = 4'h1; rst = 1'b1;
    void'($urandom(32'hf4a77364));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rdc(pfb_pkg::BRK_OFF, 32'h0, 2'b00, "clear enable");
    rdc(8'h18, 32'h0, 2'b10, "unmapped");
    wr(8'h18, 32'hff, 2'b10);
    $display("reset test done");
    wr(pfb_pkg::BW_OFF, 32'h80, 2'b00);
    chk({31'h0, bw_auto}, 32'h1, "bw_auto");
    pll_on <= 1'b1;
    repeat (30) @(posedge mclk);
    rdc(pfb_pkg::BW_OFF, 32'he0, 2'b00, "bw");
    rdc(pfb_pkg::IST_OFF, 32'h3, 2'b00, "status");
    rdc(pfb_pkg::CTRL_OFF, 32'h40, 2'b00, "flag");
    rdc(pfb_pkg::ICLR_OFF, 32'h0, 2'b00, "clear reads zero");
    repeat (4) begin
      msk = 2'($urandom);
      wr(pfb_pkg::IEN_OFF, {30'h0, msk}, 2'b00);
      rdc(pfb_pkg::IEN_OFF, {30'h0, msk}, 2'b00, "enable");
      chk({31'h0, pll_irq}, {31'h0, exp_irq(2'b11, msk)}, "irq");
    end
    $display("auto test done");
    brk_req <= 1'b1;
    wr(pfb_pkg::CTRL_OFF, 32'h0, 2'b00);
    wr(pfb_pkg::ICLR_OFF, 32'h3, 2'b00);
    rdc(pfb_pkg::CTRL_OFF, 32'h40, 2'b00, "kept flag");
    rdc(pfb_pkg::IST_OFF, 32'h3, 2'b00, "kept status");
    wr(pfb_pkg::BRK_OFF, 32'h80, 2'b00);
    wr(pfb_pkg::CTRL_OFF, 32'h0, 2'b00);
    wr(pfb_pkg::ICLR_OFF, 32'h3, 2'b00);
    rdc(pfb_pkg::CTRL_OFF, 32'h0, 2'b00, "cleared flag");
    brk_req <= 1'b0;
    repeat (4) @(posedge mclk);
    rdc(pfb_pkg::CTRL_OFF, 32'h0, 2'b00, "flag after");
    rdc(pfb_pkg::IST_OFF, 32'h0, 2'b00, "status after");
    chk({31'h0, pll_irq}, 32'h0, "irq after");
    $display("break test done");
    wr(pfb_pkg::BW_OFF, 32'h0, 2'b00);
    chk({31'h0, bw_auto}, 32'h0, "bw_auto manual");
    rdc(pfb_pkg::BW_OFF, 32'h0, 2'b00, "manual bw");
    rdc(pfb_pkg::CTRL_OFF, 32'h0, 2'b00, "manual flag");
    // loop is still locked, yet lock must read zero while tracking bit is software owned
    wr(pfb_pkg::BW_OFF, 32'h20, 2'b00);
    rdc(pfb_pkg::BW_OFF, 32'h20, 2'b00, "manual tracking");
    $display("manual test done");
    tally_and_finish();
  end
endmodule : pll_flag_break_protect_tb
